// ===== iopad_bus_model.sv
// iopad_bus_model: far side of the decoder, serial adapters and bus clock
// assumes decoder selects settle within each cycle of clock
`timescale 1ns/1ps
module iopad_bus_model
(
  // system
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // adapter side
  input  wire logic       adapter_select_low,
  input  wire logic       adapter_read,
  input  wire logic       adapter_reg_select,
  output logic [7:0]      adapter_read_data,
  // bus clock and hs status
  output logic            bus_clock_pulse,
  output logic [7:0]      hs_status
);
  logic [2:0] phase;
  logic [7:0] last;

  assign hs_status = 8'h81;
  assign bus_clock_pulse = (phase == 3'h4);

  always_ff @(posedge clock)
  begin
    if (sys_rst || phase == 3'h4)
      phase <= 3'h0;
    else
      phase <= phase + 3'h1;
  end

  // unselected bus toggles so stale bytes never look valid
  always_comb
  begin
    if (!adapter_select_low && adapter_read)
      adapter_read_data = adapter_reg_select ? 8'h96 : 8'h3C;
    else
      adapter_read_data = ~last;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      last <= 8'h00;
    else
      last <= adapter_read_data;
  end
endmodule

// ===== iopad_decoder.sv
// iopad_decoder: i/o port decoder, serial adapter selects and high port strobes
// assumes processor bus inputs are synchronous to clock
`timescale 1ns/1ps
module iopad_decoder
  import iopad_pkg::*;
(
  // system
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // processor bus
  input  wire logic       cpu_running,
  input  wire logic       io_cycle,
  input  wire logic       interrupt_ack_n,
  input  wire logic [7:0] address,
  input  wire logic       read_write,
  input  wire logic       bus_op_request,
  input  wire logic       write_pulse,
  input  wire logic       bus_clock_pulse,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_out_en,
  // chip selects
  output logic            dma_sel_n,
  output logic            remote_serial_sel_n,
  output logic            aux_serial_sel_n,
  output logic            terminal_serial_sel_n,
  output logic            high_port_group_n,
  output logic            bus_buffer_dir_n,
  output logic            cpu_buffer_dir_n,
  // serial adapter control
  output logic            adapter_select_low,
  output logic            adapter_enable,
  output logic            adapter_read,
  output logic            adapter_reg_select,
  input  wire logic [7:0] adapter_read_data,
  // high port read strobes
  output logic            hs_char_read_n,
  output logic            hs_status_read_n,
  output logic            test_status_read_n,
  output logic            test_data_read_n,
  output logic            cpu_reset_read_n,
  output logic            switch_read_n,
  output logic            sync_test_read_n,
  // high port write strobes
  output logic            hs_char_load_n,
  output logic            hs_control_write_n,
  output logic            test_control_write_n,
  output logic            test_data_write_n,
  output logic            timer_write_n,
  output logic            diag_write_n,
  output logic            bank_write_n,
  // high speed serial control and status
  input  wire logic [7:0] hs_status,
  output logic [7:0]      hs_control
);
  import iopad_pkg::*;

  logic       decode_en;
  logic       is_dma;
  logic       is_remote;
  logic       is_aux;
  logic       is_term;
  logic       is_high;
  logic       read_en;
  logic       write_en;
  logic [7:0] read_strobe_n;
  logic [7:0] write_strobe_n;
  logic       request_q;
  logic       enable_armed;
  logic       any_adapter;
  logic [7:0] next_data_out;
  logic       next_data_out_en;

  assign decode_en = cpu_running && io_cycle && interrupt_ack_n;

  // address match; all gated by decode_en
  assign is_dma    = decode_en && (address >= IOPAD_DMA_LO)
                     && (address <= IOPAD_DMA_HI);
  assign is_remote = decode_en && (address[7:1] == IOPAD_REMOTE_PAIR);
  assign is_aux    = decode_en && (address[7:1] == IOPAD_AUX_PAIR);
  assign is_term   = decode_en && (address[7:1] == IOPAD_TERM_PAIR);
  assign is_high   = decode_en && (address[7:3] == IOPAD_HIGH_GROUP);

  // unmatched or unqualified cycles leave every select high
  assign dma_sel_n             = !is_dma;
  assign remote_serial_sel_n   = !is_remote;
  assign aux_serial_sel_n      = !is_aux;
  assign terminal_serial_sel_n = !is_term;
  assign high_port_group_n     = !is_high;

  assign any_adapter = is_remote || is_aux || is_term;

  // buffer direction: low on reads from the board, low on cpu writes
  assign bus_buffer_dir_n = !(decode_en && !read_write
                              && (any_adapter || is_high || is_dma));
  assign cpu_buffer_dir_n = !(decode_en && read_write);

  assign read_en  = !high_port_group_n && bus_op_request && !read_write;
  assign write_en = !high_port_group_n && bus_op_request && read_write
                    && write_pulse;

  iopad_strobe_dec u_read_dec
  (
    .enable   (read_en),
    .select   (address[2:0]),
    .strobe_n (read_strobe_n)
  );

  iopad_strobe_dec u_write_dec
  (
    .enable   (write_en),
    .select   (address[2:0]),
    .strobe_n (write_strobe_n)
  );

  // read strobe map; EE has no read function
  assign hs_char_read_n     = read_strobe_n[IOPAD_SUB_CHAR];
  assign hs_status_read_n   = read_strobe_n[IOPAD_SUB_HS_CTRL];
  assign test_status_read_n = read_strobe_n[IOPAD_SUB_TEST];
  assign test_data_read_n   = read_strobe_n[IOPAD_SUB_TDATA];
  assign cpu_reset_read_n   = read_strobe_n[IOPAD_SUB_RESET];
  assign switch_read_n      = read_strobe_n[IOPAD_SUB_SWITCH];
  assign sync_test_read_n   = read_strobe_n[IOPAD_SUB_SYNC];

  // write strobe map; EF has no write function
  assign hs_char_load_n       = write_strobe_n[IOPAD_SUB_CHAR];
  assign hs_control_write_n   = write_strobe_n[IOPAD_SUB_HS_CTRL];
  assign test_control_write_n = write_strobe_n[IOPAD_SUB_TEST];
  assign test_data_write_n    = write_strobe_n[IOPAD_SUB_TDATA];
  assign timer_write_n        = write_strobe_n[IOPAD_SUB_RESET];
  assign diag_write_n         = write_strobe_n[IOPAD_SUB_SWITCH];
  assign bank_write_n         = write_strobe_n[IOPAD_SUB_BANK];

  // adapter pins: high selects are tied high, low select is the decode
  assign adapter_select_low = !any_adapter;
  assign adapter_read       = !read_write;
  assign adapter_reg_select = address[0];

  // request edge arms the enable; first bus clock pulse fires it
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      request_q <= 1'b0;
    end
    else
    begin
      request_q <= bus_op_request;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      enable_armed <= 1'b0;
    end
    else if (!bus_op_request)
    begin
      enable_armed <= 1'b0;
    end
    else if (!request_q)
    begin
      enable_armed <= 1'b1;
    end
    else if (bus_clock_pulse && enable_armed)
    begin
      enable_armed <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      adapter_enable <= 1'b0;
    end
    else
    begin
      adapter_enable <= any_adapter && enable_armed && bus_clock_pulse
                        && bus_op_request;
    end
  end

  // E9 write loads the high speed control latch
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hs_control <= IOPAD_HS_CTRL_RST;
    end
    else if (!hs_control_write_n)
    begin
      hs_control <= data_in;
    end
  end

  // read data return: adapter status/rx data or hs status byte
  always_comb
  begin
    next_data_out    = 8'h00;
    next_data_out_en = 1'b0;
    if (any_adapter && !read_write && bus_op_request)
    begin
      next_data_out    = adapter_read_data;
      next_data_out_en = 1'b1;
    end
    else if (!hs_status_read_n)
    begin
      next_data_out    = hs_status;
      next_data_out_en = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      data_out    <= 8'h00;
      data_out_en <= 1'b0;
    end
    else
    begin
      data_out    <= next_data_out;
      data_out_en <= next_data_out_en;
    end
  end

  // even/odd write lands in control or tx data of the selected adapter
  // (adapter itself latches data_in; decoder supplies select and reg select)

  // decode qualification, chip selects and buffer direction
  chk_dma_select: assert property (@(posedge clock) disable iff (sys_rst)
    !dma_sel_n |-> (decode_en && address[7:4] == 4'h9))
    else $error("dma select outside 90-9F");
  chk_decode_qualify: assert property (@(posedge clock) disable iff (sys_rst)
    !(cpu_running && io_cycle && interrupt_ack_n) |->
      (dma_sel_n && remote_serial_sel_n && aux_serial_sel_n
       && terminal_serial_sel_n && high_port_group_n))
    else $error("select while decoder disqualified");
  chk_remote_pair: assert property (@(posedge clock) disable iff (sys_rst)
    !remote_serial_sel_n |-> (address == IOPAD_REMOTE_CTRL
                              || address == IOPAD_REMOTE_DATA))
    else $error("remote select on wrong port");
  chk_aux_pair: assert property (@(posedge clock) disable iff (sys_rst)
    !aux_serial_sel_n |-> (address == IOPAD_AUX_CTRL
                           || address == IOPAD_AUX_DATA))
    else $error("aux select on wrong port");
  chk_term_pair: assert property (@(posedge clock) disable iff (sys_rst)
    !terminal_serial_sel_n |-> (address == IOPAD_TERM_CTRL
                                || address == IOPAD_TERM_DATA))
    else $error("terminal select on wrong port");
  chk_group_range: assert property (@(posedge clock) disable iff (sys_rst)
    !high_port_group_n |-> (decode_en && address[7:3] == IOPAD_HIGH_GROUP))
    else $error("group select outside E8-EF");
  chk_buffer_read: assert property (@(posedge clock) disable iff (sys_rst)
    !bus_buffer_dir_n |-> (decode_en && !read_write))
    else $error("board buffer driven outside a read");
  chk_buffer_write: assert property (@(posedge clock) disable iff (sys_rst)
    !cpu_buffer_dir_n |-> (decode_en && read_write))
    else $error("processor buffer driven outside a write");
  chk_buffers_apart: assert property (@(posedge clock) disable iff (sys_rst)
    bus_buffer_dir_n || cpu_buffer_dir_n)
    else $error("both buffer directions driven");

  // strobe decoders
  chk_read_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    (~read_strobe_n != 8'h00) |->
      (!high_port_group_n && bus_op_request && !read_write
       && $onehot(~read_strobe_n)))
    else $error("read strobe without enables");
  chk_write_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    (~write_strobe_n != 8'h00) |->
      (write_pulse && read_write && $onehot(~write_strobe_n)
       && write_strobe_n[address[2:0]] == 1'b0))
    else $error("write strobe without enables");
  chk_read_one: assert property (@(posedge clock) disable iff (sys_rst)
    read_en |-> ($onehot(~read_strobe_n) && !read_strobe_n[address[2:0]]))
    else $error("read decoder not one of eight");
  chk_write_one: assert property (@(posedge clock) disable iff (sys_rst)
    write_en |-> ($onehot(~write_strobe_n) && !write_strobe_n[address[2:0]]))
    else $error("write decoder not one of eight");
  chk_one_direction: assert property (@(posedge clock) disable iff (sys_rst)
    (&read_strobe_n) || (&write_strobe_n))
    else $error("read and write strobes together");
  chk_strobe_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !(read_en || write_en) |->
      (read_strobe_n == 8'hFF && write_strobe_n == 8'hFF))
    else $error("strobe without decoder enable");
  chk_reset_read: assert property (@(posedge clock) disable iff (sys_rst)
    !cpu_reset_read_n |-> (read_en && address[2:0] == IOPAD_SUB_RESET))
    else $error("reset strobe on wrong port");
  chk_sync_read: assert property (@(posedge clock) disable iff (sys_rst)
    !sync_test_read_n |-> (read_en && address[2:0] == IOPAD_SUB_SYNC))
    else $error("sync strobe on wrong port");
  chk_timer_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    !timer_write_n |-> (write_en && address[2:0] == IOPAD_SUB_RESET))
    else $error("timer strobe on wrong port");
  chk_bank_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    !bank_write_n |-> (write_en && address[2:0] == IOPAD_SUB_BANK))
    else $error("bank strobe on wrong port");

  // high speed control latch and status read
  chk_hs_latch: assert property (@(posedge clock) disable iff (sys_rst)
    !hs_control_write_n |=> (hs_control == $past(data_in)))
    else $error("hs control latch missed write");
  chk_hs_hold: assert property (@(posedge clock) disable iff (sys_rst)
    hs_control_write_n |=> $stable(hs_control))
    else $error("hs control changed without write");
  chk_hs_address: assert property (@(posedge clock) disable iff (sys_rst)
    !hs_control_write_n |->
      (address == {IOPAD_HIGH_GROUP, IOPAD_SUB_HS_CTRL} && write_pulse))
    else $error("hs control write on wrong cycle");
  chk_status_return: assert property (@(posedge clock) disable iff (sys_rst)
    !hs_status_read_n |=> (data_out_en && data_out == $past(hs_status)))
    else $error("hs status byte not returned");

  // serial adapter pins and read data
  chk_adapter_enable: assert property (@(posedge clock) disable iff (sys_rst)
    adapter_enable |-> $past(bus_clock_pulse) && $past(bus_op_request))
    else $error("adapter enable without bus clock pulse");
  chk_enable_single: assert property (@(posedge clock) disable iff (sys_rst)
    adapter_enable |=> !adapter_enable)
    else $error("adapter enable longer than one cycle");
  chk_enable_adapter: assert property (@(posedge clock) disable iff (sys_rst)
    adapter_enable |-> $past(any_adapter))
    else $error("adapter enable without adapter select");
  chk_reg_select: assert property (@(posedge clock) disable iff (sys_rst)
    !adapter_select_low |-> (adapter_reg_select == address[0]))
    else $error("register select not address bit 0");
  chk_adapter_low: assert property (@(posedge clock) disable iff (sys_rst)
    adapter_select_low ==
      (remote_serial_sel_n && aux_serial_sel_n && terminal_serial_sel_n))
    else $error("adapter low select not the decoded select");
  chk_adapter_rw: assert property (@(posedge clock) disable iff (sys_rst)
    adapter_read == !read_write)
    else $error("adapter direction not the bus direction");
  chk_adapter_return: assert property (@(posedge clock) disable iff (sys_rst)
    (any_adapter && !read_write && bus_op_request) |=>
      (data_out_en && data_out == $past(adapter_read_data)))
    else $error("adapter read byte not returned");
  chk_data_idle: assert property (@(posedge clock) disable iff (sys_rst)
    (!(any_adapter && !read_write && bus_op_request) && hs_status_read_n) |=>
      !data_out_en)
    else $error("read data valid without a read");
endmodule

// ===== iopad_pkg.sv
// iopad_pkg: constants for the system controller i/o port address decoder
// assumes a single 100 MHz clock and processor bus strobes sampled on it
// Functional notes
// - decoder enabled only when cpu running, i/o cycle, no interrupt acknowledge
// - ports 90 to 9F drive dma chip select low
// - ports CA and CB select remote serial adapter, active low
// - ports CC and CD select auxiliary serial adapter, active low
// - ports CE and CF select terminal serial adapter, active low
// - ports E8 to EF assert high port group low, enabling strobe decoders
// - two active-low buffer direction outputs steer the data buffers
// - read strobes need group, bus op request high, read/write low
// - write strobes need group, request, read/write high, write pulse high
// - exactly one strobe, chosen by low three address bits and direction
// - read strobes: E8 char, E9 status, EA test, EB data, EC reset, ED switch, EF sync
// - write strobes: E8 char, E9 control, EA test, EB data, EC timer, ED diag, EE bank
// - adapter selected by its low select alone; high selects tied high
// - adapter enable on first bus clock pulse after request rises
// - adapter read/write picks write-only or read-only registers
// - adapter register select follows address bit 0
// - even write loads control, odd write loads transmit data
// - even read returns status, odd read returns received data
// - writes latch the processor byte; reads drive the selected byte
// - E9 write clocks hs control latch; E9 read gates hs status byte
package iopad_pkg;
  localparam logic [7:0] IOPAD_DMA_LO       = 8'h90;
  localparam logic [7:0] IOPAD_DMA_HI       = 8'h9F;
  localparam logic [6:0] IOPAD_REMOTE_PAIR  = 7'h65;
  localparam logic [6:0] IOPAD_AUX_PAIR     = 7'h66;
  localparam logic [6:0] IOPAD_TERM_PAIR    = 7'h67;
  localparam logic [4:0] IOPAD_HIGH_GROUP   = 5'h1D;
  localparam logic [7:0] IOPAD_REMOTE_CTRL  = 8'hCA;
  localparam logic [7:0] IOPAD_REMOTE_DATA  = 8'hCB;
  localparam logic [7:0] IOPAD_AUX_CTRL     = 8'hCC;
  localparam logic [7:0] IOPAD_AUX_DATA     = 8'hCD;
  localparam logic [7:0] IOPAD_TERM_CTRL    = 8'hCE;
  localparam logic [7:0] IOPAD_TERM_DATA    = 8'hCF;
  localparam logic [2:0] IOPAD_SUB_CHAR     = 3'h0;
  localparam logic [2:0] IOPAD_SUB_HS_CTRL  = 3'h1;
  localparam logic [2:0] IOPAD_SUB_TEST     = 3'h2;
  localparam logic [2:0] IOPAD_SUB_TDATA    = 3'h3;
  localparam logic [2:0] IOPAD_SUB_RESET    = 3'h4;
  localparam logic [2:0] IOPAD_SUB_SWITCH   = 3'h5;
  localparam logic [2:0] IOPAD_SUB_BANK     = 3'h6;
  localparam logic [2:0] IOPAD_SUB_SYNC     = 3'h7;
  localparam logic [7:0] IOPAD_HS_CTRL_RST  = 8'h00;
  localparam int         IOPAD_ADAPTERS     = 3;
endpackage

// ===== iopad_strobe_dec.sv
// iopad_strobe_dec: one-of-eight active-low strobe decoder with enable
// assumes enable and select are settled in the same cycle
`timescale 1ns/1ps
module iopad_strobe_dec
  import iopad_pkg::*;
(
  // decode inputs
  input  wire logic       enable,
  input  wire logic [2:0] select,
  // strobes
  output logic [7:0]      strobe_n
);
  always_comb
  begin
    strobe_n = 8'hFF;
    if (enable)
    begin
      strobe_n[select] = 1'b0;
    end
  end
endmodule

// ===== tb_top.sv
// tb_top: self-checking bench for the i/o port address decoder
// assumes iopad_pkg compiled first and the bus model beside the decoder
`timescale 1ns/1ps
module tb_top;
  import iopad_pkg::*;
  logic        clock, sys_rst, cpu_running, io_cycle, interrupt_ack_n;
  logic        read_write, bus_op_request, write_pulse;
  logic [7:0]  address, data_in;
  wire         bus_clock_pulse, data_out_en, adapter_enable, bus_dir_n, cpu_dir_n;
  wire         adapter_select_low, adapter_read, adapter_reg_select;
  wire  [7:0]  data_out, adapter_read_data, hs_status, hs_control;
  wire  [18:0] sel;
  wire  [20:0] obs;
  int          errors, checked;

  assign obs = {sel, adapter_select_low, adapter_reg_select};

  iopad_decoder iopad_decoder_inst (.clock(clock), .sys_rst(sys_rst),
    .cpu_running(cpu_running), .io_cycle(io_cycle), .interrupt_ack_n(interrupt_ack_n),
    .address(address), .read_write(read_write), .bus_op_request(bus_op_request),
    .write_pulse(write_pulse), .bus_clock_pulse(bus_clock_pulse), .data_in(data_in),
    .data_out(data_out), .data_out_en(data_out_en), .dma_sel_n(sel[18]),
    .remote_serial_sel_n(sel[17]), .aux_serial_sel_n(sel[16]),
    .terminal_serial_sel_n(sel[15]), .high_port_group_n(sel[14]),
    .bus_buffer_dir_n(bus_dir_n), .cpu_buffer_dir_n(cpu_dir_n),
    .adapter_select_low(adapter_select_low),
    .adapter_enable(adapter_enable), .adapter_read(adapter_read),
    .adapter_reg_select(adapter_reg_select), .adapter_read_data(adapter_read_data),
    .hs_char_read_n(sel[13]), .hs_status_read_n(sel[12]), .test_status_read_n(sel[11]),
    .test_data_read_n(sel[10]), .cpu_reset_read_n(sel[9]), .switch_read_n(sel[8]),
    .sync_test_read_n(sel[7]), .hs_char_load_n(sel[6]), .hs_control_write_n(sel[5]),
    .test_control_write_n(sel[4]), .test_data_write_n(sel[3]), .timer_write_n(sel[2]),
    .diag_write_n(sel[1]), .bank_write_n(sel[0]), .hs_status(hs_status),
    .hs_control(hs_control));

  iopad_bus_model iopad_bus_model_inst (.clock(clock), .sys_rst(sys_rst),
    .adapter_select_low(adapter_select_low), .adapter_read(adapter_read),
    .adapter_reg_select(adapter_reg_select), .adapter_read_data(adapter_read_data),
    .bus_clock_pulse(bus_clock_pulse), .hs_status(hs_status));

  function automatic logic [20:0] expect_sel(input logic [7:0] a,
    input logic q, input logic rw, input logic req, input logic wp);
    logic [20:0] e;
    logic        grp;
    grp = q && a[7:3] == IOPAD_HIGH_GROUP;
    e[20] = !(q && a[7:4] == 4'h9);
    e[19] = !(q && a[7:1] == IOPAD_REMOTE_PAIR);
    e[18] = !(q && a[7:1] == IOPAD_AUX_PAIR);
    e[17] = !(q && a[7:1] == IOPAD_TERM_PAIR);
    e[16] = !grp;
    for (int k = 0; k < 7; k++)
    begin
      e[15 - k] = !(grp && req && !rw && a[2:0] == ((k == 6) ? 3'h7 : 3'(k)));
      e[8 - k] = !(grp && req && rw && wp && a[2:0] == 3'(k));
    end
    e[1] = e[19] & e[18] & e[17];
    e[0] = a[0];
    return e;
  endfunction

  task automatic check(input logic [20:0] seen, input logic [20:0] expected);
    checked++;
    if (seen !== expected)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic drive(input logic [7:0] a, input logic rw, input logic req,
    input logic wp, input logic [1:0] qm, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    read_write <= rw;
    bus_op_request <= req;
    write_pulse <= wp;
    data_in <= d;
    cpu_running <= (qm != 2'h1);
    io_cycle <= (qm != 2'h2);
    interrupt_ack_n <= (qm != 2'h3);
    @(negedge clock);
  endtask

  task automatic test_decode;
    logic [12:0] n;
    logic [20:0] e;
    logic [1:0]  b;
    logic        q;
    for (int i = 0; i < 8192; i++)
    begin
      n = 13'(i);
      q = (n[12:11] == 2'h0);
      e = expect_sel(n[7:0], q, n[8], n[10], n[9]);
      b = {!(q && !n[8] && !(e[20] && e[1] && e[16])), !(q && n[8])};
      drive(n[7:0], n[8], n[10], n[9], n[12:11], 8'h00);
      check(obs, e);
      check(21'({bus_dir_n, cpu_dir_n}), 21'(b));
    end
    $display("decode sweep done");
  endtask

  task automatic test_hs;
    drive(8'hE9, 1'b1, 1'b1, 1'b1, 2'h0, 8'hA5);
    drive(8'hE9, 1'b1, 1'b1, 1'b0, 2'h0, 8'h3C);
    check(21'(hs_control), 21'h0000A5);
    drive(8'hE9, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
    check(21'(hs_control), 21'h0000A5);
    drive(8'h00, 1'b0, 1'b0, 1'b0, 2'h0, 8'h00);
    check(21'({data_out_en, data_out}), 21'h000181);
    $display("hs port test done");
  endtask

  task automatic test_adapter(input logic [7:0] a, input logic [7:0] rd);
    int pk;
    int ek;
    int ne;
    logic [2:0] wr;
    pk = -1;
    ek = -1;
    ne = 0;
    drive(8'h00, 1'b0, 1'b0, 1'b0, 2'h0, 8'h00);
    for (int k = 0; k < 12; k++)
    begin
      drive(a, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
      if (k == 1)
        check(21'({adapter_read, data_out_en, data_out}), 21'({2'b11, rd}));
      if (k > 0 && pk < 0 && bus_clock_pulse === 1'b1)
        pk = k;
      if (adapter_enable === 1'b1)
      begin
        ne++;
        if (ek < 0)
          ek = k;
      end
    end
    drive(a, 1'b1, 1'b1, 1'b1, 2'h0, 8'h00);
    wr = {adapter_select_low, adapter_read, adapter_reg_select};
    check(21'(wr), 21'({2'b00, a[0]}));
    check(21'(ek), 21'(pk + 1));
    check(21'(ne), 21'h1);
    $display("adapter test done");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever
      #5 clock = ~clock;
  end

  initial
  begin
    #150000;
    errors++;
    complete_run();
  end

  initial
  begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    {cpu_running, io_cycle, interrupt_ack_n} = 3'b111;
    {read_write, bus_op_request, write_pulse} = 3'b000;
    address = 8'h00;
    data_in = 8'h00;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check(21'({adapter_enable, data_out_en, hs_control}), 21'h0);
    test_decode();
    test_hs();
    test_adapter(IOPAD_REMOTE_DATA, 8'h96);
    test_adapter(IOPAD_AUX_CTRL, 8'h3C);
    test_adapter(IOPAD_TERM_DATA, 8'h96);
    complete_run();
  end
endmodule
